// ---- adc_ctl_pkg.sv ----
`default_nettype none
package adc_ctl_pkg;
   // Register indices on the plain register port.
   localparam logic [3:0] mode_reg_addr     = 4'h0;
   localparam logic [3:0] chan_reg_addr     = 4'h1;
   localparam logic [3:0] pincfg_reg_addr   = 4'h2;
   localparam logic [3:0] res_wide_addr     = 4'h3;
   localparam logic [3:0] res_high_addr     = 4'h4;
   localparam logic [3:0] irq_stat_addr     = 4'h5;
   localparam logic [3:0] irq_mask_addr     = 4'h6;
   localparam logic [3:0] status_addr       = 4'h7;
   // Mode register fields and result format.
   localparam int run_bit_pos  = 7;
   localparam int cmp_en_pos   = 0;
   localparam int res_bits     = 10;
   localparam int res_shift    = 6;
   // Reset values.
   localparam logic [7:0]  mode_rst   = 8'h00;
   localparam logic [7:0]  chan_rst   = 8'h00;
   localparam logic [7:0]  pincfg_rst = 8'h00;
   localparam logic [15:0] wide_rst   = 16'h0000;
   localparam logic [7:0]  high_rst   = 8'h00;
   localparam logic [1:0]  mask_rst   = 2'h0;
   // Timing.
   localparam int clk_mhz       = 250;
   localparam int settle_us     = 1;
   localparam int settle_cycles = settle_us * clk_mhz;
   localparam int sample_cycles = 8;
   localparam int bit_cycles    = 4;
   typedef enum logic [1:0] {
      st_idle   = 2'b00,
      st_sample = 2'b01,
      st_convert = 2'b11
   } seq_state_e;
endpackage
`default_nettype wire

// ---- sar_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface sar_if;
   logic       start;
   logic       abort;
   logic       comp_in;
   logic       done;
   logic [9:0] code;
   logic       busy;
   logic       sampling;
   modport seq (output start, output abort, input comp_in,
                input done, input code, input busy, input sampling);
   modport core (input start, input abort, input comp_in,
                 output done, output code, output busy, output sampling);
endinterface
`default_nettype wire

// ---- sar_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module sar_core
   import adc_ctl_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic srst,
   sar_if.core       sar
);
   seq_state_e          state_q;
   logic [3:0]          bit_q;
   logic [7:0]          cnt_q;
   logic [res_bits-1:0] sar_q;
   logic                done_q;
   wire logic           cnt_end = (cnt_q == 8'h00);

   assign sar.done     = done_q;
   assign sar.code     = sar_q;
   assign sar.busy     = (state_q != st_idle);
   assign sar.sampling = (state_q == st_sample);

   // Conversion period starts at sampling and ends on the done pulse.
   always_ff @(posedge core_clk) begin
      done_q <= 1'b0;
      if (srst || sar.abort) begin
         state_q <= st_idle;
         bit_q   <= 4'h0;
         cnt_q   <= 8'h00;
         sar_q   <= '0;
      end else begin
         case (state_q)
            st_idle: if (sar.start) begin
               state_q <= st_sample;
               cnt_q   <= 8'(sample_cycles - 1);
            end
            st_sample: if (cnt_end) begin
               state_q <= st_convert;
               bit_q   <= 4'(res_bits - 1);
               sar_q   <= 10'h200;
               cnt_q   <= 8'(bit_cycles - 1);
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
            st_convert: if (cnt_end) begin
               sar_q[bit_q] <= sar.comp_in;
               if (bit_q == 4'h0) begin
                  state_q <= st_idle;
                  done_q  <= 1'b1;
               end else begin
                  sar_q[bit_q - 4'h1] <= 1'b1;
                  bit_q <= bit_q - 4'h1;
                  cnt_q <= 8'(bit_cycles - 1);
               end
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
            default: state_q <= st_idle;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- settle_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module settle_timer
   import adc_ctl_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic enable,
   output logic      settled
);
   // Counts how long the comparator enable bit has been set before a start.
   logic [8:0] cnt_q;
   always_ff @(posedge core_clk) begin
      if (srst || !enable) begin
         cnt_q <= 9'h000;
      end else if (cnt_q != 9'(settle_cycles)) begin
         cnt_q <= cnt_q + 9'h001;
      end
   end
   assign settled = (cnt_q == 9'(settle_cycles));
endmodule
`default_nettype wire

// ---- adc_sequencer.sv ----
// How it works
// - Result is a 10-bit code.
// - Conversion period includes sampling, ends at result.
// - Deep stop halts converter; hardware clears run bit.
// - Colliding result read returns old value first.
// - Config write beats result store, no interrupt.
// - Channel write leaves interrupt flag alone.
// - Old-channel result may set flag before rewrite.
// - Early start marks first result as suspect.
// - Config write drops the result; result registers keep old code.
// - Channel rewrite aborts and restarts conversion.
// - Clearing run bit stops, keeps last result.
// - Running: store, interrupt, start next conversion.
// - Wide result 16 bits, high byte 8 bits.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer
   import adc_ctl_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [1:0] reg_wbyte,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [15:0]     reg_rdata,
   input  wire logic       deep_stop,
   input  wire logic       comparator_out,
   output logic [2:0]      analog_channel,
   output logic            sample_switch,
   output logic            comparator_power,
   output logic [7:0]      analog_pin_config,
   output logic            conv_end_irq,
   output logic            irq_out
);
   logic [7:0]  converter_mode_reg_q;
   logic [7:0]  channel_select_reg_q;
   logic [7:0]  analog_pin_config_reg_q;
   logic [15:0] result_wide_reg_q;
   logic [7:0]  result_high_byte_reg_q;
   logic [1:0]  irq_stat_q;
   logic [1:0]  irq_mask_q;
   logic        pend_valid_q;
   logic [9:0]  pend_code_q;
   logic        suspect_q;
   logic        first_pending_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic        conv_end_irq_q;
   logic        irq_q;
   logic        sample_q;
   logic [2:0]  chan_q;
   logic        cmp_pwr_q;
   logic [7:0]  pincfg_out_q;
   logic        busy_prev_q;

   sar_if sar ();

   sar_core u_core (
      .core_clk (core_clk),
      .srst     (srst),
      .sar      (sar)
   );

   wire logic settled;
   settle_timer u_settle (
      .core_clk (core_clk),
      .srst     (srst),
      .enable   (converter_mode_reg_q[cmp_en_pos]),
      .settled  (settled)
   );

   wire logic wr_mode   = reg_wr && (reg_addr == mode_reg_addr);
   wire logic wr_chan   = reg_wr && (reg_addr == chan_reg_addr);
   wire logic wr_pincfg = reg_wr && (reg_addr == pincfg_reg_addr);
   wire logic wr_cfg    = wr_mode || wr_chan || wr_pincfg;
   wire logic wr_stat   = reg_wr && (reg_addr == irq_stat_addr);
   wire logic wr_mask   = reg_wr && (reg_addr == irq_mask_addr);
   wire logic rd_result = reg_rd && ((reg_addr == res_wide_addr) ||
                                     (reg_addr == res_high_addr));
   wire logic run       = converter_mode_reg_q[run_bit_pos] && !deep_stop;
   wire logic run_next  = wr_mode ? reg_wdata[run_bit_pos] : run;
   // The write-lane strobes select nothing; reg_wbyte[1] only drives unused_lane.
   wire logic unused_lane = reg_wbyte[1];

   // Candidate result: either fresh from the core or held over a read.
   wire logic       new_done = sar.done;
   wire logic       have_res = new_done || pend_valid_q;
   wire logic [9:0] res_code = new_done ? sar.code : pend_code_q;
   // A result read in the same cycle, without a config write, defers the store by one cycle.
   wire logic defer     = have_res && rd_result && !wr_cfg;
   wire logic store     = have_res && !rd_result && !wr_cfg;
   wire logic abort     = wr_chan || !run;
   wire logic start     = run_next && !sar.busy && !wr_chan;
   wire logic early     = !converter_mode_reg_q[cmp_en_pos] || !settled;
   wire logic [1:0] ev  = {store && first_pending_q && suspect_q, store};
   wire logic [1:0] stat_d = (irq_stat_q & ~(wr_stat ? reg_wdata[1:0]
                                                     : 2'h0)) | ev;

   assign sar.start   = start && !abort;
   assign sar.abort   = abort;
   assign sar.comp_in = comparator_out;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         converter_mode_reg_q    <= mode_rst;
         channel_select_reg_q    <= chan_rst;
         analog_pin_config_reg_q <= pincfg_rst;
         irq_mask_q              <= mask_rst;
      end else begin
         if (wr_mode) begin
            converter_mode_reg_q <= reg_wdata;
         end else if (deep_stop) begin
            converter_mode_reg_q[run_bit_pos] <= 1'b0;
         end
         // The flag is not touched here on purpose.
         if (wr_chan) begin
            channel_select_reg_q <= reg_wdata;
         end
         if (wr_pincfg) begin
            analog_pin_config_reg_q <= reg_wdata;
         end
         if (wr_mask) begin
            irq_mask_q <= reg_wdata[1:0];
         end
      end
   end

   // A config write drops any waiting result, so the registers keep
   // the old code rather than a corrupted one.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         result_wide_reg_q      <= wide_rst;
         result_high_byte_reg_q <= high_rst;
         pend_valid_q           <= 1'b0;
         pend_code_q            <= 10'h000;
      end else begin
         pend_valid_q <= defer;
         if (defer) begin
            pend_code_q <= res_code;
         end
         if (store) begin
            result_wide_reg_q      <= {res_code, 6'h00};
            result_high_byte_reg_q <= res_code[9:2];
         end
      end
   end

   // Set wins over the write-one-to-clear.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_stat_q      <= 2'h0;
         conv_end_irq_q  <= 1'b0;
         irq_q           <= 1'b0;
         suspect_q       <= 1'b0;
         first_pending_q <= 1'b0;
         busy_prev_q     <= 1'b0;
      end else begin
         irq_stat_q     <= stat_d;
         conv_end_irq_q <= store;
         irq_q          <= |(stat_d & irq_mask_q);
         busy_prev_q    <= sar.busy;
         // Only a start from a stopped core counts as a first result; a
         // back-to-back start in the done cycle sees busy from before.
         if (sar.start && !busy_prev_q) begin
            first_pending_q <= 1'b1;
            suspect_q       <= early;
         end else if (store) begin
            first_pending_q <= 1'b0;
            suspect_q       <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_q      <= 16'h0000;
         sample_q     <= 1'b0;
         chan_q       <= 3'h0;
         cmp_pwr_q    <= 1'b0;
         pincfg_out_q <= 8'h00;
      end else begin
         rdata_q      <= reg_rd ? rdata_d : 16'h0000;
         sample_q     <= sar.sampling;
         chan_q       <= channel_select_reg_q[2:0];
         cmp_pwr_q    <= converter_mode_reg_q[cmp_en_pos] && !deep_stop;
         pincfg_out_q <= analog_pin_config_reg_q;
      end
   end

   always_comb begin
      case (reg_addr)
         mode_reg_addr:   rdata_d = {8'h00, converter_mode_reg_q};
         chan_reg_addr:   rdata_d = {8'h00, channel_select_reg_q};
         pincfg_reg_addr: rdata_d = {8'h00, analog_pin_config_reg_q};
         res_wide_addr:   rdata_d = result_wide_reg_q;
         res_high_addr:   rdata_d = {8'h00, result_high_byte_reg_q};
         irq_stat_addr:   rdata_d = {14'h0000, irq_stat_q};
         irq_mask_addr:   rdata_d = {14'h0000, irq_mask_q};
         status_addr:     rdata_d = {13'h0000, suspect_q, sar.sampling,
                                     sar.busy};
         default:         rdata_d = 16'h0000;
      endcase
   end

   assign reg_rdata         = rdata_q;
   assign analog_channel    = chan_q;
   assign sample_switch     = sample_q;
   assign comparator_power  = cmp_pwr_q;
   assign analog_pin_config = pincfg_out_q;
   assign conv_end_irq      = conv_end_irq_q;
   assign irq_out           = irq_q;
endmodule
`default_nettype wire

// ---- adc_sequencer_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_asserts
   import adc_ctl_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [3:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        deep_stop,
   input wire logic [2:0]  analog_channel,
   input wire logic        sample_switch,
   input wire logic        comparator_power,
   input wire logic        conv_end_irq,
   input wire logic        irq_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   wire logic cfg_wr  = reg_wr && (reg_addr <= pincfg_reg_addr);
   wire logic chan_wr = reg_wr && (reg_addr == chan_reg_addr);
   wire logic stop_wr = reg_wr && (reg_addr == mode_reg_addr)
                        && !reg_wdata[run_bit_pos];
   sequence sample_hold;
      sample_switch [*8] ##1 !sample_switch;
   endsequence
   sequence quiet_after;
      !conv_end_irq [*8];
   endsequence
   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_wide_fmt: assert property (
      reg_rd && reg_addr == res_wide_addr |=> reg_rdata[5:0] == 6'h00)
      else $error("wide result low bits not zero");
   a_high_fmt: assert property (
      reg_rd && reg_addr == res_high_addr |=> reg_rdata[15:8] == 8'h00)
      else $error("high byte result upper bits not zero");
   a_sample_len: assert property (
      $rose(sample_switch) |-> sample_hold or (##[0:8] (reg_wr || deep_stop)))
      else $error("sampling window length wrong");
   a_cfg_blocks_irq: assert property (
      cfg_wr |=> !conv_end_irq)
      else $error("interrupt raised beside a config write");
   a_chan_restart: assert property (
      chan_wr |=> quiet_after)
      else $error("result stored right after channel rewrite");
   a_chan_sel: assert property (
      chan_wr |-> ##2 analog_channel == $past(reg_wdata[2:0], 2))
      else $error("channel output does not follow write");
   a_stop_quiet: assert property (
      stop_wr |=> quiet_after)
      else $error("result stored after run bit cleared");
   a_chan_flag: assert property (
      irq_out && chan_wr |=> irq_out)
      else $error("channel write dropped the interrupt");
   a_irq_pulse: assert property (
      conv_end_irq |=> !conv_end_irq)
      else $error("conversion end pulse longer than one cycle");
   a_deep_stop: assert property (
      deep_stop [*3] |-> !comparator_power && !sample_switch && !conv_end_irq)
      else $error("converter active in deep stop");
endmodule
bind adc_sequencer adc_sequencer_asserts chk_i (.core_clk, .srst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .deep_stop, .analog_channel,
   .sample_switch, .comparator_power, .conv_end_irq, .irq_out);
`default_nettype wire

// ---- analog_front_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module analog_front_model
   import adc_ctl_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic [79:0] levels,
   input  wire logic [2:0]  analog_channel,
   input  wire logic        sample_switch,
   input  wire logic        comparator_power,
   output logic             comparator_out
);
   logic [9:0] held_q = 10'h000;
   logic [7:0] cnt_q  = 8'hff;
   logic       flip_q = 1'b0;
   wire  logic [7:0] bit_idx = 8'(cnt_q / bit_cycles);
   // Unpowered or outside the bit slots the output toggles, so a late
   // sample in the sequencer never sees a stable value for free.
   assign comparator_out = (comparator_power && bit_idx < 8'd10) ?
                           held_q[4'd9 - bit_idx[3:0]] : flip_q;
   always_ff @(posedge core_clk) begin
      flip_q <= ~flip_q;
      if (sample_switch) begin
         held_q <= levels[analog_channel*10 +: 10];
         cnt_q  <= 8'h00;
      end else if (cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
   import adc_ctl_pkg::*;
   logic        core_clk, srst, reg_wr, reg_rd, deep_stop, hit;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [15:0] reg_rdata, d;
   logic [2:0]  analog_channel;
   logic        sample_switch, comparator_power, comparator_out;
   logic        conv_end_irq, irq_out;
   logic [79:0] lv;
   logic [9:0]  old;
   logic [7:0]  pin_cfg, pc;
   int          err_total, comparisons, seed, k;
   adc_sequencer uut (.core_clk, .srst, .reg_addr, .reg_wdata,
      .reg_wbyte(2'h0), .reg_wr, .reg_rd, .reg_rdata, .deep_stop,
      .comparator_out, .analog_channel, .sample_switch, .comparator_power,
      .analog_pin_config(pin_cfg), .conv_end_irq, .irq_out);
   analog_front_model afe (.core_clk, .levels(lv), .analog_channel,
      .sample_switch, .comparator_power, .comparator_out);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [15:0] exp_wide(input logic [9:0] c);
      return {c, 6'h00};
   endfunction
   function automatic logic [15:0] exp_high(input logic [9:0] c);
      return {8'h00, c[9:2]};
   endfunction
   function automatic logic [9:0] lvl(input int ch);
      return lv[ch*10 +: 10];
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_irq(input int lim);
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         tick();
         hit = (conv_end_irq === 1'b1);
      end
   endtask
   task automatic mid_conv();
      for (int i = 0; i < 80 && sample_switch !== 1'b1; i++) tick();
      for (int i = 0; i < 20 && sample_switch !== 1'b0; i++) tick();
      repeat (10) tick();
   endtask
   task automatic print_verdict();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #80000;
      err_total++;
      print_verdict();
   end
   initial begin
      seed = 92172;
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      deep_stop = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      for (k = 0; k < 8; k++) lv[k*10 +: 10] = 10'($random(seed));
      lv[9:0] = 10'h3ff;
      lv[79:70] = 10'h000;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      for (k = 0; k < 9; k++) begin
         rd(4'(k));
         chk(d, 16'h0000);
      end
      wr(4'h8, 8'hff);
      rd(4'h8);
      chk(d, 16'h0000);
      pc = 8'($random(seed));
      wr(pincfg_reg_addr, pc);
      tick();
      chk(pin_cfg, pc);
      rd(pincfg_reg_addr);
      chk(d, {8'h00, pc});
      $display("test 1 done");
      wr(mode_reg_addr, 8'h81);
      wait_irq(100);
      chk(hit, 1);
      rd(irq_stat_addr);
      chk(d[1:0], 2'b11);
      chk(irq_out, 0);
      wr(irq_mask_addr, 8'h01);
      tick();
      chk(irq_out, 1);
      wr(mode_reg_addr, 8'h01);
      wr(irq_stat_addr, 8'h03);
      rd(irq_stat_addr);
      chk(d, 16'h0000);
      chk(irq_out, 0);
      $display("test 2 done");
      repeat (settle_cycles + 10) @(posedge core_clk);
      for (k = 0; k < 8; k++) begin
         wr(chan_reg_addr, 8'(k));
         wr(mode_reg_addr, 8'h81);
         wait_irq(100);
         chk(hit, 1);
         rd(res_wide_addr);
         chk(d, exp_wide(lvl(k)));
         rd(res_high_addr);
         chk(d, exp_high(lvl(k)));
         rd(irq_stat_addr);
         chk(d[1:0], 2'b01);
         wr(mode_reg_addr, 8'h01);
         wr(irq_stat_addr, 8'h03);
      end
      $display("test 3 done");
      wr(chan_reg_addr, 8'h02);
      wr(mode_reg_addr, 8'h81);
      wait_irq(100);
      wait_irq(60);
      chk(hit, 1);
      mid_conv();
      wr(mode_reg_addr, 8'h01);
      wait_irq(120);
      chk(hit, 0);
      rd(res_wide_addr);
      chk(d, exp_wide(lvl(2)));
      $display("test 4 done");
      wr(irq_stat_addr, 8'h03);
      wr(mode_reg_addr, 8'h81);
      wait_irq(100);
      mid_conv();
      wr(chan_reg_addr, 8'h05);
      tick();
      chk(irq_out, 1);
      rd(irq_stat_addr);
      chk(d[0], 1);
      wait_irq(100);
      chk(hit, 1);
      rd(res_wide_addr);
      chk(d, exp_wide(lvl(5)));
      chk(analog_channel, 3'h5);
      $display("test 5 done");
      // Step the access across the end of conversion one cycle at a time.
      for (k = 0; k < 16; k++) begin
         wait_irq(120);
         old = lvl(5);
         lv[50 +: 10] = 10'($random(seed));
         repeat (42 + k / 2) @(posedge core_clk);
         // The done cycle ends 49 edges after the irq edge; only k of 11
         // writes into it, and only k of 10 reads into it.
         if (k % 2 == 1) begin
            wr(mode_reg_addr, 8'h81);
            repeat (8) tick();
            rd(res_wide_addr);
            chk(d, exp_wide(k == 11 ? old : lvl(5)));
         end else begin
            rd(res_wide_addr);
            chk(d, exp_wide(k > 11 ? lvl(5) : old));
            wait_irq(60);
            rd(res_wide_addr);
            chk(d, exp_wide(lvl(5)));
         end
      end
      $display("test 6 done");
      mid_conv();
      @(posedge core_clk);
      deep_stop <= 1'b1;
      repeat (4) tick();
      chk(comparator_power, 0);
      chk(sample_switch, 0);
      wait_irq(120);
      chk(hit, 0);
      @(posedge core_clk);
      deep_stop <= 1'b0;
      wr(irq_stat_addr, 8'h03);
      $display("test 7 done");
      print_verdict();
   end
endmodule
`default_nettype wire
